// file: gcs_pkg.sv
// shared constants and types for the coprocessor state save/restore block
package gcs_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CVA    = 8'h04;
  localparam logic [7:0] OFS_AUX    = 8'h08;
  localparam logic [7:0] OFS_LEN    = 8'h0C;
  localparam logic [7:0] OFS_CTRL   = 8'h10;
  localparam logic [7:0] OFS_ERR    = 8'h24;
  localparam logic [7:0] OFS_K2     = 8'h28;
  localparam logic [7:0] OFS_DIR    = 8'h2C;
  localparam logic [7:0] OFS_MIX    = 8'h48;
  localparam logic [7:0] OFS_CMPV   = 8'h4C;
  localparam logic [7:0] OFS_MASK   = 8'h50;
  localparam logic [7:0] OFS_CARRY  = 8'h54;
  localparam logic [7:0] OFS_FG     = 8'h58;
  localparam logic [7:0] OFS_BG     = 8'h5C;
  localparam logic [7:0] OFS_DIM    = 8'h60;
  localparam logic [7:0] OFS_MORG   = 8'h6C;
  localparam logic [7:0] OFS_SRC    = 8'h70;
  localparam logic [7:0] OFS_PAT    = 8'h74;
  localparam logic [7:0] OFS_DST    = 8'h78;
  localparam logic [7:0] OFS_POP    = 8'h7C;
  localparam logic [7:0] OFS_PORT_A = 8'h80;
  localparam logic [7:0] OFS_PORT_B = 8'h84;
  // control byte bit positions (byte lane 1 of offset 10)
  localparam int CTRL_SRSEL = 1;
  localparam int CTRL_SUSP  = 3;
  localparam int CTRL_SUSPD = 4;
  localparam int CTRL_TERM  = 5;
  localparam int CTRL_BUSY  = 7;
  // state part lengths in doublewords
  localparam logic [3:0] LEN_A = 4'h8;
  localparam logic [3:0] LEN_B = 4'h8;
  // state word indexes, part A
  localparam logic [2:0] A_POP = 3'h0;
  localparam logic [2:0] A_DIM = 3'h1;
  localparam logic [2:0] A_FG  = 3'h2;
  localparam logic [2:0] A_BG  = 3'h3;
  localparam logic [2:0] A_SRC = 3'h4;
  localparam logic [2:0] A_PAT = 3'h5;
  localparam logic [2:0] A_DST = 3'h6;
  localparam logic [2:0] A_ERR = 3'h7;
  // state word indexes, part B
  localparam logic [2:0] B_DIR   = 3'h0;
  localparam logic [2:0] B_K2    = 3'h1;
  localparam logic [2:0] B_MIX   = 3'h2;
  localparam logic [2:0] B_CMPV  = 3'h3;
  localparam logic [2:0] B_MASK  = 3'h4;
  localparam logic [2:0] B_CARRY = 3'h5;
  localparam logic [2:0] B_MORG  = 3'h6;
  localparam logic [2:0] B_ENG   = 3'h7;
  // pixel operation fields
  localparam int         POP_OP_LSB  = 28;
  localparam int         POP_SRC_LSB = 20;
  localparam int         POP_PAT_LSB = 12;
  localparam logic [3:0] OP_LINE     = 4'h3;
  localparam logic [3:0] PAT_FIXED   = 4'h8;
  // operating mode strobe decode
  localparam logic [2:0] MODE_EXT       = 3'h4;
  localparam int         MODE_ORDER_BIT = 3;
  // memory cycle timing
  localparam int         CLK_NS     = 100;
  localparam int         MEMCYC_NS  = 400;
  localparam logic [2:0] MEMCYC_CYC = 3'((MEMCYC_NS + CLK_NS - 1) / CLK_NS);
  // engine states
  typedef enum logic [1:0] {ENG_IDLE, ENG_RUN, ENG_HALT} gcs_eng_t;
endpackage

// file: gcs_lane_swap.sv
// reverses lanes of a four-lane word when the swapped layout is active
`timescale 1ns/1ps
module gcs_lane_swap #(
  parameter int LW = 8
) (
  // control
  input  wire logic            swap,
  // data
  input  wire logic [4*LW-1:0] din,
  output logic      [4*LW-1:0] dout
);
  // lane n maps to lane 3-n
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign dout[i*LW +: LW] = swap ? din[(3-i)*LW +: LW] : din[i*LW +: LW];
  end
endmodule

// file: gcs_seq_port.sv
// one save/restore data port: doubleword sequencer with byte assembly
`timescale 1ns/1ps
module gcs_seq_port #(
  parameter logic [3:0] LEN = 4'h8
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // sequence restart on new setup
  input  wire logic        clear,
  // host access to the port
  input  wire logic        access,
  input  wire logic [3:0]  be,
  input  wire logic [31:0] wdata,
  // sequence state
  output logic      [3:0]  idx,
  output logic             step,
  output logic      [31:0] word,
  output logic             done
);
  logic [3:0]  seen;
  logic [31:0] stage;
  logic        full;

  // merge new lanes over the staged ones
  for (genvar i = 0; i < 4; i++) begin : g_merge
    assign word[i*8 +: 8] = be[i] ? wdata[i*8 +: 8] : stage[i*8 +: 8];
  end

  // advance only once all four lanes were moved
  assign full = (seen | be) == 4'hF;
  assign done = idx == LEN;
  assign step = access && full && !done;

  // position and lane tracking
  always_ff @(posedge clk) begin
    if (reset || clear) begin
      idx   <= 4'h0;
      seen  <= 4'h0;
      stage <= 32'h0;
    end else if (access && !done) begin
      stage <= word;
      if (full) begin
        idx  <= idx + 4'h1;
        seen <= 4'h0;
      end else begin
        seen <= seen | be;
      end
    end
  end
endmodule

// file: gcs_top.sv
// drawing coprocessor register interface with suspend, state save and restore
//
// Contract
// - a suspend request halts the operation only after its memory cycle ends
// - clearing suspend resumes the restored operation
// - two 32-bit data ports carry all internal state
// - two read-only lengths give part A and B doublewords, under 1KB
// - each save read returns the next doubleword of that port's part once all four bytes of the previous one were read
// - after a complete save the coprocessor is back in reset state
// - restore writes are accepted in the order they were read
// - byte layout is picked when extended mode is set in operating mode
// - swapped layout reverses bytes per word except direction steps and pixel op
// - only the listed registers read back directly, others only via save
// - most registers keep their values across an operation
// - line error term updates throughout a line draw
// - source coordinates update when the source map is used
// - pattern coordinates update unless pattern is fixed foreground
// - destination coordinates update in every operation
// - don't-care bits are written as zero and masked on read
// - control bit 1 selects save when one and restore when zero
// - suspended bit 4 sets on actual halt and clears on restart
// - control bit 3 requests suspend; suspending flushes the translation buffer
// - control bit 5 terminates, clears itself and masks interrupts
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module gcs_top import gcs_pkg::*; (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic [3:0]  reg_be,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // operating mode register strobe
  input  wire logic        opmode_wr,
  input  wire logic [3:0]  opmode_data,
  // status
  output logic             engine_active_flag,
  output logic             mem_cycle,
  output logic             tlb_flush,
  output logic             irq_mask_clear
);
  gcs_eng_t    eng_state;
  logic [2:0]  cyc_cnt;
  logic [15:0] remaining;
  logic        swap_layout;
  logic        keep_order;
  logic        suspend_req;
  logic        sr_save;
  logic        term_req;
  logic        suspended_flag;
  logic [31:0] regs_a [0:7];
  logic [31:0] regs_b [0:6];
  logic [31:0] cva;
  logic [31:0] wd;
  logic [3:0]  be;
  logic [31:0] rd_word;
  logic [31:0] rd_swapped;
  logic [7:0]  wb;
  logic [4:0]  wmap;
  logic        ctrl_wr;
  logic        start;
  logic        step_done;
  logic        save_done;
  logic        soft_reset;
  logic [31:0] eng_word;
  logic [3:0]  port_idx  [0:1];
  logic        port_step [0:1];
  logic [31:0] port_word [0:1];
  logic        port_done [0:1];

  // offset to {valid, part B, index}
  function automatic logic [4:0] map_ofs(input logic [7:0] a);
    case (a)
      OFS_POP:   map_ofs = {2'b10, A_POP};
      OFS_DIM:   map_ofs = {2'b10, A_DIM};
      OFS_FG:    map_ofs = {2'b10, A_FG};
      OFS_BG:    map_ofs = {2'b10, A_BG};
      OFS_SRC:   map_ofs = {2'b10, A_SRC};
      OFS_PAT:   map_ofs = {2'b10, A_PAT};
      OFS_DST:   map_ofs = {2'b10, A_DST};
      OFS_ERR:   map_ofs = {2'b10, A_ERR};
      OFS_DIR:   map_ofs = {2'b11, B_DIR};
      OFS_K2:    map_ofs = {2'b11, B_K2};
      OFS_MIX:   map_ofs = {2'b11, B_MIX};
      OFS_CMPV:  map_ofs = {2'b11, B_CMPV};
      OFS_MASK:  map_ofs = {2'b11, B_MASK};
      OFS_CARRY: map_ofs = {2'b11, B_CARRY};
      OFS_MORG:  map_ofs = {2'b11, B_MORG};
      default:   map_ofs = 5'h00;
    endcase
  endfunction

  // keep untouched lanes of a register
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] m);
    merge = {m[3] ? n[31:24] : o[31:24], m[2] ? n[23:16] : o[23:16],
             m[1] ? n[15:8] : o[15:8], m[0] ? n[7:0] : o[7:0]};
  endfunction

  // byte order into and out of the register space
  assign keep_order = reg_addr == OFS_DIR || reg_addr == OFS_POP;
  gcs_lane_swap #(.LW(8)) u_wswap (
    .swap (swap_layout && !keep_order),
    .din  (reg_wdata),
    .dout (wd)
  );
  gcs_lane_swap #(.LW(1)) u_bswap (
    .swap (swap_layout && !keep_order),
    .din  (reg_be),
    .dout (be)
  );
  gcs_lane_swap #(.LW(8)) u_rswap (
    .swap (swap_layout && !keep_order),
    .din  (rd_word),
    .dout (rd_swapped)
  );

  // layout chosen only when extended mode is entered
  always_ff @(posedge clk) begin
    if (reset) begin
      swap_layout <= 1'b0;
    end else if (opmode_wr && opmode_data[2:0] == MODE_EXT) begin
      swap_layout <= opmode_data[MODE_ORDER_BIT];
    end
  end

  // decode of host writes
  assign wb        = wd[15:8];
  assign wmap      = map_ofs(reg_addr);
  assign ctrl_wr   = reg_wr && reg_addr == OFS_CTRL && be[1];
  // a suspended operation blocks new starts until it resumes, its save completes or it is terminated
  assign start     = reg_wr && reg_addr == OFS_POP && be[3] && !suspended_flag;
  assign step_done = eng_state == ENG_RUN && cyc_cnt == 3'h0;
  assign save_done = suspended_flag && sr_save && port_done[0] && port_done[1];
  assign soft_reset = term_req || save_done;
  assign eng_word  = {engine_active_flag, 15'h0000, remaining};

  // control byte; terminate lasts one cycle then clears itself
  always_ff @(posedge clk) begin
    if (reset || soft_reset) begin
      suspend_req <= 1'b0;
      sr_save     <= 1'b0;
      term_req    <= 1'b0;
    end else if (ctrl_wr) begin
      suspend_req <= wb[CTRL_SUSP];
      sr_save     <= wb[CTRL_SRSEL];
      term_req    <= wb[CTRL_TERM];
    end
  end

  // terminate re-masks interrupts outside this block
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_mask_clear <= 1'b0;
    end else begin
      irq_mask_clear <= term_req;
    end
  end

  // one sequencer per data port, restarted by every control write with byte lane 1 enabled
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [7:0] ofs;
    logic       acc;
    assign ofs = (p == 0) ? OFS_PORT_A : OFS_PORT_B;
    assign acc = suspended_flag && reg_addr == ofs &&
                 ((reg_rd && sr_save) || (reg_wr && !sr_save));
    gcs_seq_port #(.LEN((p == 0) ? LEN_A : LEN_B)) u_port (
      .clk   (clk),
      .reset (reset),
      .clear (ctrl_wr),
      .access(acc),
      .be    (be),
      .wdata (wd),
      .idx   (port_idx[p]),
      .step  (port_step[p]),
      .word  (port_word[p]),
      .done  (port_done[p])
    );
  end

  // engine sequencing: memory cycles, suspend at cycle boundary, resume
  always_ff @(posedge clk) begin
    if (reset || soft_reset) begin
      eng_state          <= ENG_IDLE;
      cyc_cnt            <= 3'h0;
      remaining          <= 16'h0000;
      engine_active_flag <= 1'b0;
      suspended_flag     <= 1'b0;
      mem_cycle          <= 1'b0;
      tlb_flush          <= 1'b0;
    end else begin
      tlb_flush <= 1'b0;
      case (eng_state)
        ENG_IDLE: begin
          if (suspend_req) begin
            eng_state      <= ENG_HALT;
            suspended_flag <= 1'b1;
            tlb_flush      <= 1'b1;
          end else if (start) begin
            eng_state          <= ENG_RUN;
            engine_active_flag <= 1'b1;
            remaining          <= regs_a[A_DIM][15:0];
            cyc_cnt            <= MEMCYC_CYC - 3'h1;
            mem_cycle          <= 1'b1;
          end
        end
        ENG_RUN: begin
          if (cyc_cnt != 3'h0) begin
            cyc_cnt <= cyc_cnt - 3'h1;
          end else if (remaining == 16'h0000) begin
            eng_state          <= ENG_IDLE;
            engine_active_flag <= 1'b0;
            mem_cycle          <= 1'b0;
          end else begin
            remaining <= remaining - 16'h0001;
            // the running memory cycle always completes first
            if (suspend_req) begin
              eng_state      <= ENG_HALT;
              suspended_flag <= 1'b1;
              tlb_flush      <= 1'b1;
              mem_cycle      <= 1'b0;
            end else begin
              cyc_cnt <= MEMCYC_CYC - 3'h1;
            end
          end
        end
        ENG_HALT: begin
          if (port_step[1] && !sr_save && port_idx[1][2:0] == B_ENG) begin
            engine_active_flag <= port_word[1][31];
            remaining          <= port_word[1][15:0];
          end
          if (!suspend_req) begin
            suspended_flag <= 1'b0;
            eng_state      <= engine_active_flag ? ENG_RUN : ENG_IDLE;
            mem_cycle      <= engine_active_flag;
            cyc_cnt        <= MEMCYC_CYC - 3'h1;
          end
        end
        default: eng_state <= ENG_IDLE;
      endcase
    end
  end

  // register state: host writes, restore words, per-step updates
  always_ff @(posedge clk) begin
    if (reset || soft_reset) begin
      for (int i = 0; i < 8; i++) begin
        regs_a[i] <= 32'h0;
      end
      for (int i = 0; i < 7; i++) begin
        regs_b[i] <= 32'h0;
      end
      cva <= 32'h0;
    end else begin
      if (reg_wr && wmap[4] && !wmap[3]) begin
        regs_a[wmap[2:0]] <= merge(regs_a[wmap[2:0]], wd, be);
      end
      if (reg_wr && wmap[4] && wmap[3]) begin
        regs_b[wmap[2:0]] <= merge(regs_b[wmap[2:0]], wd, be);
      end
      // restore words land in read order
      if (port_step[0] && !sr_save) begin
        regs_a[port_idx[0][2:0]] <= port_word[0];
      end
      if (port_step[1] && !sr_save && port_idx[1][2:0] != B_ENG) begin
        regs_b[port_idx[1][2:0]] <= port_word[1];
      end
      // only coordinates, current address and error term move; others hold for reuse
      if (step_done) begin
        regs_a[A_DST][15:0] <= regs_a[A_DST][15:0] + 16'h0001;
        cva <= {regs_a[A_DST][31:16], regs_a[A_DST][15:0] + 16'h0001};
        if (regs_a[A_POP][POP_SRC_LSB +: 4] != 4'h0) begin
          regs_a[A_SRC][15:0] <= regs_a[A_SRC][15:0] + 16'h0001;
        end
        if (regs_a[A_POP][POP_PAT_LSB +: 4] != PAT_FIXED) begin
          regs_a[A_PAT][15:0] <= regs_a[A_PAT][15:0] + 16'h0001;
        end
        if (regs_a[A_POP][POP_OP_LSB +: 4] == OP_LINE) begin
          regs_a[A_ERR][31:16] <= regs_a[A_ERR][31] ?
            regs_a[A_ERR][31:16] + regs_a[A_ERR][15:0] :
            regs_a[A_ERR][31:16] + regs_b[B_K2][15:0];
        end
      end
    end
  end

  // direct read view; write-only and unused bits read zero
  always_comb begin
    rd_word = 32'h0;
    case (reg_addr)
      OFS_CVA:  rd_word = cva;
      OFS_AUX:  rd_word = {24'h000000, engine_active_flag, 7'h00};
      OFS_LEN:  rd_word = {16'h0000, 4'h0, LEN_B, 4'h0, LEN_A};
      OFS_CTRL: rd_word = {16'h0000, engine_active_flag, 1'b0, term_req, suspended_flag,
                           suspend_req, 1'b0, sr_save, 1'b0, 8'h00};
      OFS_ERR:  rd_word = {regs_a[A_ERR][31:16], 16'h0000};
      OFS_SRC:  rd_word = regs_a[A_SRC];
      OFS_PAT:  rd_word = regs_a[A_PAT];
      OFS_DST:  rd_word = regs_a[A_DST];
      OFS_PORT_A: begin
        if (suspended_flag && sr_save && !port_done[0]) begin
          rd_word = regs_a[port_idx[0][2:0]];
        end
      end
      OFS_PORT_B: begin
        if (suspended_flag && sr_save && !port_done[1]) begin
          rd_word = (port_idx[1][2:0] == B_ENG) ? eng_word : regs_b[port_idx[1][2:0]];
        end
      end
      default:  rd_word = 32'h0;
    endcase
  end

  // read data stands the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata <= rd_swapped;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  halt_at_boundary_a: assert property ($rose(suspended_flag) |->
    $past(eng_state) == ENG_IDLE || $past(cyc_cnt) == 3'h0)
    else $error("suspend took effect inside a memory cycle");
  resume_run_a: assert property (eng_state == ENG_HALT && !suspend_req &&
    engine_active_flag && !soft_reset |=> eng_state == ENG_RUN && !suspended_flag && mem_cycle)
    else $error("suspended operation did not resume");
  flush_pulse_a: assert property (tlb_flush |-> $rose(suspended_flag) ##1 !tlb_flush)
    else $error("translation flush not a single pulse at suspend");
  term_self_clear_a: assert property (term_req |=>
    !term_req && eng_state == ENG_IDLE && !engine_active_flag && irq_mask_clear)
    else $error("terminate did not clear and reset");
  seq_restart_a: assert property (ctrl_wr |=> port_idx[0] == 4'h0 && port_idx[1] == 4'h0)
    else $error("control write left a port sequence running");
  port_advance_a: assert property (port_step[0] |=>
    port_idx[0] == $past(port_idx[0]) + 4'h1)
    else $error("port A did not advance one doubleword");
  save_resets_a: assert property (save_done |=>
    regs_a[A_POP] == 32'h0 && !suspended_flag && eng_state == ENG_IDLE)
    else $error("complete save did not reset the coprocessor");
  dest_step_a: assert property (step_done && !soft_reset |=>
    regs_a[A_DST][15:0] == $past(regs_a[A_DST][15:0]) + 16'h0001)
    else $error("destination did not step");
  len_read_a: assert property (reg_rd && reg_addr == OFS_LEN && !swap_layout |=>
    reg_rdata == {16'h0000, 4'h0, LEN_B, 4'h0, LEN_A})
    else $error("length read wrong");
  len_swap_a: assert property (reg_rd && reg_addr == OFS_LEN && swap_layout |=>
    reg_rdata == {4'h0, LEN_A, 4'h0, LEN_B, 16'h0000})
    else $error("swapped layout not applied");

  cover property ($rose(suspended_flag) && $past(eng_state) == ENG_RUN);
  cover property (save_done);
  cover property (eng_state == ENG_HALT ##1 eng_state == ENG_RUN);
endmodule

// file: gcs_host.sv
// host processor model: register port master and state save/restore software
`timescale 1ns/1ps
module gcs_host import gcs_pkg::*; (
  // clock
  input  wire logic        clk,
  // register port
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  output logic      [3:0]  reg_be,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [31:0] reg_rdata,
  // operating mode strobe
  output logic             opmode_wr,
  output logic      [3:0]  opmode_data
);
  logic [31:0] part_a [8];
  logic [31:0] part_b [8];
  // bus idle from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_be = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    opmode_wr = 1'b0;
    opmode_data = 4'h0;
  end
  // one-cycle write; data inverted after so a stale value never matches
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_be <= 4'hF;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // one-cycle read; data stand only in the following cycle
  task automatic rd(input logic [7:0] a, input logic [3:0] b, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_be <= b;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // read-modify-write: bits outside the mask keep what was read back
  task automatic rmw(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] d;
    rd(a, 4'hF, d);
    wr(a, (d & ~m) | (v & m));
  endtask
  task automatic set_mode(input logic [3:0] m);
    @(posedge clk);
    opmode_data <= m;
    opmode_wr <= 1'b1;
    @(posedge clk);
    opmode_wr <= 1'b0;
  endtask
  // save: both ports in turn, exact count; first port A word split in halves
  task automatic save_all();
    logic [31:0] lo;
    logic [31:0] hi;
    rd(OFS_PORT_A, 4'h3, lo);
    rd(OFS_PORT_A, 4'hC, hi);
    part_a[0] = {hi[31:16], lo[15:0]};
    rd(OFS_PORT_B, 4'hF, part_b[0]);
    for (int i = 1; i < int'(LEN_A); i++) begin
      rd(OFS_PORT_A, 4'hF, part_a[i]);
      rd(OFS_PORT_B, 4'hF, part_b[i]);
    end
  endtask
  // restore in the order read, first out first in
  task automatic restore_all();
    for (int i = 0; i < int'(LEN_A); i++) begin
      wr(OFS_PORT_A, part_a[i]);
      wr(OFS_PORT_B, part_b[i]);
    end
  endtask
endmodule

// file: tb_gcs_top.sv
// self-checking bench for the coprocessor state save/restore block
`timescale 1ns/1ps
module tb_gcs_top;
  import gcs_pkg::*;
  typedef struct packed {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} gcs_row_t;
  localparam logic [31:0] LENS = {16'h0, 4'h0, LEN_B, 4'h0, LEN_A};
  localparam gcs_row_t ROWS [6] = '{'{OFS_LEN, 1'b0, 32'h0, LENS}, '{OFS_CTRL, 1'b0, 32'h0, 32'h0},
    '{OFS_SRC, 1'b1, 32'h00050003, 32'h00050003}, '{OFS_PAT, 1'b1, 32'h12345678, 32'h12345678},
    '{OFS_AUX, 1'b0, 32'h0, 32'h0}, '{OFS_CVA, 1'b0, 32'h0, 32'h0}};
  localparam logic [7:0] B_OFS [7] = '{OFS_DIR, OFS_K2, OFS_MIX, OFS_CMPV, OFS_MASK, OFS_CARRY, OFS_MORG};
  logic        clk;
  logic        reset;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [3:0]  reg_be;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        opmode_wr;
  logic [3:0]  opmode_data;
  logic        engine_active_flag;
  logic        mem_cycle;
  logic        tlb_flush;
  logic        irq_mask_clear;
  int          num_errors;
  int          checks_done;
  int          n_flush;
  int          n_mask;
  gcs_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .opmode_wr(opmode_wr), .opmode_data(opmode_data));
  gcs_top DUT (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .opmode_wr(opmode_wr), .opmode_data(opmode_data),
    .engine_active_flag(engine_active_flag), .mem_cycle(mem_cycle), .tlb_flush(tlb_flush),
    .irq_mask_clear(irq_mask_clear));
  // 10 MHz clock
  initial clk = 1'b0;
  always #50 clk = ~clk;
  // count one-cycle status pulses
  always @(posedge clk) begin
    if (tlb_flush === 1'b1) n_flush++;
    if (irq_mask_clear === 1'b1) n_mask++;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    u_host.rd(a, 4'hF, d);
    chk(n, e, d & m);
  endtask
  // bounded wait for the engine to go idle
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    #1;
    while (engine_active_flag !== 1'b0 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("busy", 32'h0, 32'(engine_active_flag));
  endtask
  task automatic wait_susp(input logic s);
    logic [31:0] c;
    int n;
    n = 0;
    do begin
      u_host.rd(OFS_CTRL, 4'hF, c);
      n++;
    end while (c[8+CTRL_SUSPD] !== s && n < 20);
    chk("suspended", 32'(s), 32'(c[8+CTRL_SUSPD]));
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // watchdog: the tests need under a thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    num_errors++;
    $display("FAIL watchdog expected finish seen hang");
    report_and_stop();
  end
  initial begin
    reset = 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    // register table: reset values and read-back; read-only and reserved places never written
    foreach (ROWS[i]) begin
      if (ROWS[i].w) u_host.wr(ROWS[i].a, ROWS[i].d);
      rchk("row", ROWS[i].a, 32'hFFFFFFFF, ROWS[i].e);
    end
    $display("table done");
    // short line draw to completion
    u_host.wr(OFS_SRC, 32'h00000005);
    u_host.wr(OFS_PAT, 32'h0);
    u_host.wr(OFS_DST, 32'h00020010);
    u_host.wr(OFS_ERR, 32'h00000001);
    u_host.wr(OFS_K2, 32'h00000002);
    u_host.wr(OFS_DIM, 32'h00000003);
    u_host.wr(OFS_POP, 32'h30108000);
    wait_idle();
    rchk("dst", OFS_DST, 32'hFFFFFFFF, 32'h00020014);
    rchk("src", OFS_SRC, 32'hFFFFFFFF, 32'h00000009);
    rchk("pat", OFS_PAT, 32'hFFFFFFFF, 32'h0);
    rchk("err", OFS_ERR, 32'hFFFF0000, 32'h00080000);
    rchk("cva", OFS_CVA, 32'hFFFFFFFF, 32'h00020014);
    $display("line done");
    // long pattern operation, suspended midway and saved
    foreach (B_OFS[i]) u_host.wr(B_OFS[i], 32'h5A000000 | 32'(B_OFS[i]));
    u_host.wr(OFS_FG, 32'h5A000058);
    u_host.wr(OFS_BG, 32'h5A00005C);
    u_host.wr(OFS_DST, 32'h00010000);
    u_host.wr(OFS_DIM, 32'h00000063);
    u_host.wr(OFS_POP, 32'h20000000);
    repeat (40) @(posedge clk);
    #1;
    chk("mem", 32'h1, 32'(mem_cycle));
    rchk("aux", OFS_AUX, 32'h00000080, 32'h00000080);
    u_host.wr(OFS_CTRL, 32'h00000A00);
    wait_susp(1'b1);
    chk("mem", 32'h0, 32'(mem_cycle));
    chk("flush", 32'h1, 32'(n_flush));
    u_host.save_all();
    chk("a0", 32'h20000000, u_host.part_a[0]);
    chk("a1", 32'h00000063, u_host.part_a[1]);
    chk("a3", 32'h5A00005C, u_host.part_a[3]);
    foreach (B_OFS[i]) chk("b", 32'h5A000000 | 32'(B_OFS[i]), u_host.part_b[i]);
    chk("b7", 32'h1, 32'(u_host.part_b[7][31]));
    rchk("dst", OFS_DST, 32'hFFFFFFFF, 32'h0);
    rchk("ctrl", OFS_CTRL, 32'h0000FF00, 32'h0);
    $display("save done");
    // restore, then resume to the end
    u_host.wr(OFS_CTRL, 32'h00000800);
    wait_susp(1'b1);
    u_host.restore_all();
    rchk("dst", OFS_DST, 32'hFFFFFFFF, u_host.part_a[6]);
    u_host.rmw(OFS_CTRL, 32'h00000800, 32'h0);
    wait_susp(1'b0);
    wait_idle();
    rchk("dst", OFS_DST, 32'hFFFFFFFF, 32'h00010064);
    rchk("pat", OFS_PAT, 32'hFFFFFFFF, 32'h00000064);
    rchk("src", OFS_SRC, 32'hFFFFFFFF, 32'h00000009);
    $display("restore done");
    // terminate while idle, then mid-operation; the earlier suspension already cleared on resume
    u_host.wr(OFS_CTRL, 32'h00002000);
    u_host.wr(OFS_DIM, 32'h00000063);
    u_host.wr(OFS_POP, 32'h20000000);
    repeat (10) @(posedge clk);
    u_host.wr(OFS_CTRL, 32'h00002000);
    wait_idle();
    chk("mask", 32'h2, 32'(n_mask));
    rchk("ctrl", OFS_CTRL, 32'h0000FF00, 32'h0);
    $display("terminate done");
    // swapped byte layout
    u_host.set_mode(4'hC);
    rchk("len", OFS_LEN, 32'hFFFFFFFF, 32'h08080000);
    u_host.wr(OFS_SRC, 32'h11223344);
    u_host.set_mode(4'h4);
    rchk("src", OFS_SRC, 32'hFFFFFFFF, 32'h44332211);
    // layout bit outside extended mode must not latch
    u_host.set_mode(4'h9);
    rchk("len", OFS_LEN, 32'hFFFFFFFF, LENS);
    $display("layout done");
    report_and_stop();
  end
endmodule
